// *** verilog/dncr_defs.svh ***
// offsets, field positions, reset values and host map for the nco control bank
// assumes an 8-bit write-only control port with a 4-bit address
`ifndef DNCR_DEFS_SVH
`define DNCR_DEFS_SVH
// ****************************************************************
// control port addresses
// ****************************************************************
`define DNCR_ADDR_SIC 4'hc
`define DNCR_ADDR_OSC 4'hd
`define DNCR_ADDR_TTC 4'he
`define DNCR_ADDR_UPD 4'hf
// ****************************************************************
// reset values and fields
// ****************************************************************
`define DNCR_RST_SIC 8'h01
`define DNCR_RST_OSC 8'hf8
`define DNCR_RST_TTC 8'h10
`define DNCR_BIT_CF_EN 0
`define DNCR_BIT_RSV_HI 7
`define DNCR_BIT_SF_EN 6
`define DNCR_BIT_FB_EN 5
`define DNCR_OSC_RSV_MASK 8'h9f
`define DNCR_TTC_TIM_LO 4
`define DNCR_TTC_TIM_HI 5
`define DNCR_TTC_SAFE_00 8'h00
`define DNCR_TTC_SAFE_30 8'h30
`define DNCR_CF_QUARTER 48'h4000_0000_0000
// ****************************************************************
// host register map, byte addresses on ahb-lite
// ****************************************************************
`define DNCR_HOFS_CMD 32'h0000_0000
`define DNCR_HOFS_CFG 32'h0000_0004
`define DNCR_HOFS_PIN 32'h0000_0008
`define DNCR_HOFS_STS 32'h0000_000c
`define DNCR_CMD_ADDR_LSB 0
`define DNCR_CMD_DATA_LSB 8
`define DNCR_CFG_SF_USED 0
`define DNCR_CFG_TIM_30 1
`define DNCR_RST_CFG 2'b00
`endif

// *** verilog/dncr_pkg.sv ***
// types shared by both ends of the nco control port
// assumes dncr_defs.svh carries every number
package dncr_pkg;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef logic [3:0] dncr_addr_t;
    typedef logic [7:0] dncr_byte_t;
    typedef enum logic [2:0] {
        DNCR_INIT_TTC,
        DNCR_INIT_OSC,
        DNCR_INIT_UPD,
        DNCR_RUN
    } dncr_hstate_t;
endpackage : dncr_pkg

// *** verilog/dncr_if.sv ***
// parallel write-only control port between host and nco control bank
// assumes both ends run on the one sample clock
`timescale 1ns/1ps
`default_nettype none
interface dncr_if;
    import dncr_pkg::*;
    dncr_addr_t wr_addr;
    dncr_byte_t wr_data;
    logic wr_strobe;
    logic update;
    modport host (output wr_addr, output wr_data, output wr_strobe, output update);
    modport dev (input wr_addr, input wr_data, input wr_strobe, input update);
endinterface : dncr_if
`default_nettype wire

// *** verilog/dncr_device.sv ***
// nco control bank: registers 12 to 15 of the synthesizer control port,
// their path gates and a phase accumulator that uses them
// assumes the host drives the port from logic on i_core_clk
//
// Summary of operation
// - address 12 bit 0 gates center word
// - reset enables center path, reads 01h
// - address 13 resets F8h, reserved bits kept
// - address 13 bit 6 gates serial word
// - reset sequence clears serial enable when unused
// - address 13 bit 5 enables accumulator feedback
// - address 14 resets 10h, host writes 00h/30h
// - address 14 bits 5:4 pick converter timing
// - any write to address 15 updates
`timescale 1ns/1ps
`default_nettype none
`include "dncr_defs.svh"
module dncr_device #(
    parameter int CF_W = 48,
    parameter int SF_W = 40
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    dncr_if.dev port,
    input wire logic [CF_W-1:0] i_center_freq_word,
    input wire logic [SF_W-1:0] i_serial_freq_word,
    output logic [CF_W-1:0] o_center_freq_path,
    output logic [CF_W-1:0] o_serial_freq_path,
    output logic o_acc_feedback_en,
    output logic [1:0] o_dac_timing_sel,
    output logic [7:0] o_serial_input_control,
    output logic [7:0] o_oscillator_control,
    output logic [7:0] o_test_timing_control,
    output logic o_update,
    output logic [CF_W-1:0] o_phase
);
    import dncr_pkg::*;

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    // the serial word sits under the top bits of the center word
    if (SF_W > CF_W) begin : g_bad_sf_width
        $error("dncr_device: SF_W must not exceed CF_W");
    end
    // narrower words could not hold the byte-wide weights the bank assumes
    if (SF_W < 8 || CF_W < 8) begin : g_bad_width
        $error("dncr_device: CF_W and SF_W must be at least 8");
    end

    // ****************************************************************
    // master copies, written by the port
    // ****************************************************************
    dncr_byte_t serial_input_control_m;
    dncr_byte_t oscillator_control_m;
    dncr_byte_t test_timing_control_m;
    dncr_byte_t next_serial_input_control_m;
    dncr_byte_t next_oscillator_control_m;
    dncr_byte_t next_test_timing_control_m;

    // active copies, seen by the data path
    dncr_byte_t serial_input_control;
    dncr_byte_t oscillator_control;
    dncr_byte_t test_timing_control;
    dncr_byte_t next_serial_input_control;
    dncr_byte_t next_oscillator_control;
    dncr_byte_t next_test_timing_control;

    // update_q only reports the transfer; the actives move on the event itself
    logic update_now;
    logic next_update;
    logic update_q;

    // masters take the byte on the strobe; nothing is stored for address 15
    always_comb begin
        next_serial_input_control_m = serial_input_control_m;
        next_oscillator_control_m = oscillator_control_m;
        next_test_timing_control_m = test_timing_control_m;
        // addresses 0 to 11 belong to the lower bank and fall through here
        if (port.wr_strobe) begin
            if (port.wr_addr == `DNCR_ADDR_SIC) begin
                next_serial_input_control_m = port.wr_data;
            end else if (port.wr_addr == `DNCR_ADDR_OSC) begin
                // reserved bits are stored as written; the host keeps them
                next_oscillator_control_m = port.wr_data;
            end else if (port.wr_addr == `DNCR_ADDR_TTC) begin
                next_test_timing_control_m = port.wr_data;
            end
        end
    end

    // masters only register what the block above picked
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            serial_input_control_m <= `DNCR_RST_SIC;
            oscillator_control_m <= `DNCR_RST_OSC;
            test_timing_control_m <= `DNCR_RST_TTC;
        end else begin
            serial_input_control_m <= next_serial_input_control_m;
            oscillator_control_m <= next_oscillator_control_m;
            test_timing_control_m <= next_test_timing_control_m;
        end
    end

    // ****************************************************************
    // update transfer
    // ****************************************************************
    // pin or a write to the phantom address; data written is ignored
    assign update_now = port.update
        || (port.wr_strobe && port.wr_addr == `DNCR_ADDR_UPD);

    // actives load the next master values so a byte written in the
    // same cycle as the pin update is not left behind
    always_comb begin
        next_serial_input_control = serial_input_control;
        next_oscillator_control = oscillator_control;
        next_test_timing_control = test_timing_control;
        next_update = update_now;
        if (update_now) begin
            next_serial_input_control = next_serial_input_control_m;
            next_oscillator_control = next_oscillator_control_m;
            next_test_timing_control = next_test_timing_control_m;
        end
    end

    // reset loads the actives too, so the paths restart from the defaults
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            serial_input_control <= `DNCR_RST_SIC;
            oscillator_control <= `DNCR_RST_OSC;
            test_timing_control <= `DNCR_RST_TTC;
            update_q <= 1'b0;
        end else begin
            serial_input_control <= next_serial_input_control;
            oscillator_control <= next_oscillator_control;
            test_timing_control <= next_test_timing_control;
            update_q <= next_update;
        end
    end

    // ****************************************************************
    // path gates and accumulator
    // ****************************************************************
    // every path value is CF_W wide; the serial word is padded below
    logic [CF_W-1:0] cf_gated;
    logic [CF_W-1:0] sf_gated;
    logic [CF_W-1:0] acc_base;
    logic [CF_W-1:0] next_center_freq_path;
    logic [CF_W-1:0] next_serial_freq_path;
    logic [CF_W-1:0] next_phase;
    logic [CF_W-1:0] center_freq_path;
    logic [CF_W-1:0] serial_freq_path;
    logic [CF_W-1:0] phase;

    // gates only zero the path; the stored words upstream are untouched
    always_comb begin
        cf_gated = '0;
        sf_gated = '0;
        if (serial_input_control[`DNCR_BIT_CF_EN]) begin
            cf_gated = i_center_freq_word;
        end
        if (oscillator_control[`DNCR_BIT_SF_EN]) begin
            // serial word is weighted like the top bits of the center word;
            // a shift keeps equal widths legal where a zero-width fill is not
            sf_gated = CF_W'(i_serial_freq_word) << (CF_W - SF_W);
        end
        acc_base = '0;
        if (oscillator_control[`DNCR_BIT_FB_EN]) begin
            acc_base = phase;
        end
        next_center_freq_path = cf_gated;
        next_serial_freq_path = sf_gated;
        // with feedback off the accumulator just shows the summed step
        // the sum wraps at CF_W bits, which is the phase turning over
        next_phase = acc_base + cf_gated + sf_gated;
    end

    // paths lag the active bits by one cycle, as the phase does
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            center_freq_path <= '0;
            serial_freq_path <= '0;
            phase <= '0;
        end else begin
            center_freq_path <= next_center_freq_path;
            serial_freq_path <= next_serial_freq_path;
            phase <= next_phase;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // converter timing field; code 01b is only the reset leftover
    assign o_dac_timing_sel = test_timing_control[`DNCR_TTC_TIM_HI:`DNCR_TTC_TIM_LO];
    assign o_acc_feedback_en = oscillator_control[`DNCR_BIT_FB_EN];
    // actives are brought out so the host end can be checked against them
    assign o_serial_input_control = serial_input_control;
    assign o_oscillator_control = oscillator_control;
    assign o_test_timing_control = test_timing_control;
    assign o_update = update_q;
    assign o_center_freq_path = center_freq_path;
    assign o_serial_freq_path = serial_freq_path;
    assign o_phase = phase;
endmodule : dncr_device
`default_nettype wire

// *** verilog/dncr_host.sv ***
// host end: an ahb-lite slave whose registers drive the nco control port,
// plus the write sequence every reset requires
// assumes a single ahb-lite master and the device on the same clock
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dncr_defs.svh"
module dncr_host (
    input wire logic i_core_clk,
    input wire logic i_srst,
    dncr_if.host port,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata
);
    import dncr_pkg::*;

    // ****************************************************************
    // ahb-lite data phase tracking
    // ****************************************************************
    logic dp_wr;
    logic dp_rd;
    logic [31:0] dp_addr;
    logic next_dp_wr;
    logic next_dp_rd;
    logic [31:0] next_dp_addr;
    logic take;
    logic stall;
    logic [1:0] cfg;
    logic [1:0] next_cfg;
    logic [31:0] hrdata;
    logic [31:0] next_hrdata;
    dncr_hstate_t state;
    dncr_hstate_t next_state;
    dncr_addr_t wr_addr;
    dncr_byte_t wr_data;
    logic wr_strobe;
    logic update;
    dncr_addr_t next_wr_addr;
    dncr_byte_t next_wr_data;
    logic next_wr_strobe;
    logic next_update;
    dncr_byte_t cmd_data;

    // port writes wait in the data phase until the reset sequence is done
    assign stall = (dp_wr && state != DNCR_RUN);
    assign take = i_hsel && i_htrans[1] && i_hready;
    assign cmd_data = i_hwdata[`DNCR_CMD_DATA_LSB +: 8];

    always_comb begin
        next_dp_wr = dp_wr;
        next_dp_rd = dp_rd;
        next_dp_addr = dp_addr;
        next_hrdata = hrdata;
        if (i_hready) begin
            next_dp_wr = take && i_hwrite;
            next_dp_rd = take && !i_hwrite;
            next_dp_addr = i_haddr;
            next_hrdata = 32'h0000_0000;
            // read data is registered in the address phase
            if (take && !i_hwrite) begin
                if (i_haddr == `DNCR_HOFS_CFG) begin
                    next_hrdata = {30'h0000_0000, cfg};
                end else if (i_haddr == `DNCR_HOFS_STS) begin
                    next_hrdata = {16'h0000, wr_data, 7'h00, state == DNCR_RUN};
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
        end else begin
            dp_wr <= next_dp_wr;
            dp_rd <= next_dp_rd;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
        end
    end

    // ****************************************************************
    // reset sequence and port drive
    // ****************************************************************
    // one port write per cycle; reserved and timing bits are forced legal
    always_comb begin
        next_state = state;
        next_cfg = cfg;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_strobe = 1'b0;
        next_update = 1'b0;
        case (state)
            DNCR_INIT_TTC: begin
                next_wr_addr = `DNCR_ADDR_TTC;
                next_wr_data = cfg[`DNCR_CFG_TIM_30] ? `DNCR_TTC_SAFE_30
                    : `DNCR_TTC_SAFE_00;
                next_wr_strobe = 1'b1;
                next_state = DNCR_INIT_OSC;
            end
            DNCR_INIT_OSC: begin
                next_wr_addr = `DNCR_ADDR_OSC;
                next_wr_data = `DNCR_RST_OSC;
                next_wr_data[`DNCR_BIT_SF_EN] = cfg[`DNCR_CFG_SF_USED];
                next_wr_strobe = 1'b1;
                next_state = DNCR_INIT_UPD;
            end
            DNCR_INIT_UPD: begin
                next_wr_addr = `DNCR_ADDR_UPD;
                next_wr_strobe = 1'b1;
                next_state = DNCR_RUN;
            end
            default: begin
                if (dp_wr && dp_addr == `DNCR_HOFS_CMD) begin
                    next_wr_addr = i_hwdata[`DNCR_CMD_ADDR_LSB +: 4];
                    next_wr_data = cmd_data;
                    next_wr_strobe = 1'b1;
                    if (next_wr_addr == `DNCR_ADDR_OSC) begin
                        next_wr_data = (cmd_data & ~`DNCR_OSC_RSV_MASK)
                            | (`DNCR_RST_OSC & `DNCR_OSC_RSV_MASK);
                    end else if (next_wr_addr == `DNCR_ADDR_TTC) begin
                        // only the two legal bytes go out; bit 5 picks which
                        next_wr_data = cmd_data[`DNCR_TTC_TIM_HI] ? `DNCR_TTC_SAFE_30
                            : `DNCR_TTC_SAFE_00;
                    end
                end else if (dp_wr && dp_addr == `DNCR_HOFS_CFG) begin
                    next_cfg = i_hwdata[1:0];
                    // reset clears cfg, so a new choice reruns the sequence now
                    next_state = DNCR_INIT_TTC;
                end else if (dp_wr && dp_addr == `DNCR_HOFS_PIN) begin
                    next_update = i_hwdata[0];
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            state <= DNCR_INIT_TTC;
            cfg <= `DNCR_RST_CFG;
            wr_addr <= 4'h0;
            wr_data <= 8'h00;
            wr_strobe <= 1'b0;
            update <= 1'b0;
        end else begin
            state <= next_state;
            cfg <= next_cfg;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_strobe <= next_wr_strobe;
            update <= next_update;
        end
    end

    assign port.wr_addr = wr_addr;
    assign port.wr_data = wr_data;
    assign port.wr_strobe = wr_strobe;
    assign port.update = update;
    assign o_hreadyout = !stall;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata;
endmodule : dncr_host
`default_nettype wire

// *** verif/dncr_props.sv ***
// assertions on the nco control port and the active copies it feeds
// assumes the bench instantiates it beside the port interface, no bind
`timescale 1ns/1ps
`default_nettype none
`include "dncr_defs.svh"
module dncr_props #(
    parameter int CF_W = 48,
    parameter int SF_W = 40
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire dncr_pkg::dncr_addr_t wr_addr,
    input wire dncr_pkg::dncr_byte_t wr_data,
    input wire logic wr_strobe,
    input wire logic update,
    input wire logic [CF_W-1:0] i_center_freq_word,
    input wire logic [SF_W-1:0] i_serial_freq_word,
    input wire logic [CF_W-1:0] o_center_freq_path,
    input wire logic [CF_W-1:0] o_serial_freq_path,
    input wire logic o_acc_feedback_en,
    input wire logic [1:0] o_dac_timing_sel,
    input wire logic [7:0] o_serial_input_control,
    input wire logic [7:0] o_oscillator_control,
    input wire logic [7:0] o_test_timing_control,
    input wire logic o_update
);
    import dncr_pkg::*;
    // ****************
    // helpers
    // ****************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);
    logic upd_now;
    // the pin and a write to the last address are one and the same event
    assign upd_now = update | (wr_strobe & (wr_addr == `DNCR_ADDR_UPD));
    sequence to_ttc;
        wr_strobe && wr_addr == `DNCR_ADDR_TTC;
    endsequence
    sequence to_osc;
        wr_strobe && wr_addr == `DNCR_ADDR_OSC;
    endsequence
    // timing write first, then the oscillator word, then the transfer
    sequence init_writes;
        to_ttc ##1 to_osc ##1 upd_now;
    endsequence
    // ****************
    // properties
    // ****************
    chk_reset_values: assert property (
        $fell(i_srst) |-> o_serial_input_control == `DNCR_RST_SIC
        && o_oscillator_control == `DNCR_RST_OSC && o_test_timing_control == `DNCR_RST_TTC)
        else $error("active copies not at reset values");
    chk_init_writes: assert property (
        $fell(i_srst) |-> ##[1:2] init_writes)
        else $error("reset write sequence missing");
    chk_reserved_kept: assert property (
        to_osc |-> (wr_data & `DNCR_OSC_RSV_MASK) == (`DNCR_RST_OSC & `DNCR_OSC_RSV_MASK))
        else $error("reserved oscillator bits changed");
    chk_timing_safe: assert property (
        to_ttc |-> wr_data == `DNCR_TTC_SAFE_00 || wr_data == `DNCR_TTC_SAFE_30)
        else $error("illegal timing register value");
    chk_update_pulse: assert property (
        upd_now |=> o_update)
        else $error("update event without transfer");
    chk_update_cause: assert property (
        o_update |-> $past(upd_now))
        else $error("transfer without update event");
    chk_active_hold: assert property (
        !upd_now |=> $stable(o_oscillator_control) && $stable(o_test_timing_control)
        && $stable(o_serial_input_control))
        else $error("active copy changed without update");
    chk_feedback_bit: assert property (
        o_acc_feedback_en == o_oscillator_control[`DNCR_BIT_FB_EN])
        else $error("feedback enable differs from active bit");
    chk_timing_bits: assert property (
        o_dac_timing_sel == o_test_timing_control[5:4])
        else $error("timing select differs from active field");
    chk_center_gate: assert property (
        1'b1 |=> o_center_freq_path == ($past(o_serial_input_control[`DNCR_BIT_CF_EN])
        ? $past(i_center_freq_word) : '0))
        else $error("center path gate wrong");
    chk_serial_gate: assert property (
        1'b1 |=> o_serial_freq_path == ($past(o_oscillator_control[`DNCR_BIT_SF_EN])
        ? (CF_W'($past(i_serial_freq_word)) << (CF_W - SF_W)) : '0))
        else $error("serial path gate wrong");
endmodule : dncr_props
`default_nettype wire

// *** verif/test_dncr_nco_control_regs.sv ***
// bench for both ends of the nco control port, host reached over ahb-lite
// assumes one ahb master, the bench, and the host slave on one clock
`timescale 1ns/1ps
`default_nettype none
`include "dncr_defs.svh"
module test_dncr_nco_control_regs;
    import dncr_pkg::*;
    localparam logic [39:0] SF_WORD = 40'h12_3456_789a;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic [47:0] cf_word = `DNCR_CF_QUARTER;
    logic [39:0] sf_word = SF_WORD;
    logic [47:0] cf_path;
    logic [47:0] sf_path;
    logic fb_en;
    logic [1:0] tim;
    logic [7:0] sic;
    logic [7:0] osc;
    logic [7:0] ttc;
    logic upd;
    logic [47:0] phase;
    int err_count = 0;
    int comparisons = 0;
    dncr_if dncr_if_inst ();
    dncr_host dncr_host_inst (.i_core_clk(i_core_clk), .i_srst(i_srst), .port(dncr_if_inst),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
        .o_hresp(hresp), .o_hrdata(hrdata));
    dncr_device #(.CF_W(48), .SF_W(40)) dncr_device_inst (.i_core_clk(i_core_clk),
        .i_srst(i_srst), .port(dncr_if_inst), .i_center_freq_word(cf_word),
        .i_serial_freq_word(sf_word), .o_center_freq_path(cf_path), .o_serial_freq_path(sf_path),
        .o_acc_feedback_en(fb_en), .o_dac_timing_sel(tim), .o_serial_input_control(sic),
        .o_oscillator_control(osc), .o_test_timing_control(ttc), .o_update(upd), .o_phase(phase));
    dncr_props #(.CF_W(48), .SF_W(40)) dncr_props_inst (.i_core_clk(i_core_clk),
        .i_srst(i_srst), .wr_addr(dncr_if_inst.wr_addr), .wr_data(dncr_if_inst.wr_data),
        .wr_strobe(dncr_if_inst.wr_strobe), .update(dncr_if_inst.update),
        .i_center_freq_word(cf_word), .i_serial_freq_word(sf_word), .o_center_freq_path(cf_path),
        .o_serial_freq_path(sf_path), .o_acc_feedback_en(fb_en), .o_dac_timing_sel(tim),
        .o_serial_input_control(sic), .o_oscillator_control(osc),
        .o_test_timing_control(ttc), .o_update(upd));
    // ****************
    // tasks
    // ****************
    // clock: 25 ns period
    initial begin
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    task automatic tick();
        @(posedge i_core_clk);
        #1;
    endtask : tick
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // single word transfer; waits on hready with no cycle count assumed
    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                            output logic [31:0] rd);
        @(posedge i_core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge i_core_clk);
        while (hready !== 1'b1) @(posedge i_core_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge i_core_clk);
        while (hready !== 1'b1) @(posedge i_core_clk);
        rd = hrdata;
    endtask : ahb_xfer
    task automatic port_wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] r;
        ahb_xfer(1'b1, `DNCR_HOFS_CMD, {16'h0, d, 4'h0, a}, r);
    endtask : port_wr
    task automatic wait_update();
        int n;
        n = 0;
        while (upd !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        check("update", 64'(upd), 64'h1);
    endtask : wait_update
    // polls the init-done flag after every reset
    task automatic wait_init(input logic [7:0] osc_exp, input logic [7:0] ttc_exp);
        logic [31:0] r;
        int n;
        r = 32'h0;
        n = 0;
        while (r[0] !== 1'b1 && n < 20) begin
            ahb_xfer(1'b0, `DNCR_HOFS_STS, 32'h0, r);
            n++;
        end
        check("init", 64'(r[0]), 64'h1);
        check("sts data", 64'(r[15:8]), 64'(osc_exp));
        check("hresp", 64'(hresp), 64'h0);
        check("sic", 64'(sic), 64'h01);
        check("osc", 64'(osc), 64'(osc_exp));
        check("ttc", 64'(ttc), 64'(ttc_exp));
        check("fb", 64'(fb_en), 64'h1);
        check("cf path", 64'(cf_path), 64'(`DNCR_CF_QUARTER));
    endtask : wait_init
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    // ****************
    // tests
    // ****************
    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_core_clk);
        err_count++;
        wrap_up();
    end
    initial begin
        logic [31:0] r;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        wait_init(8'hb8, 8'h00);
        $display("test reset defaults done");
        // master write alone must not reach the active copy
        port_wr(`DNCR_ADDR_OSC, 8'h00);
        repeat (4) tick();
        check("osc held", 64'(osc), 64'hb8);
        ahb_xfer(1'b1, `DNCR_HOFS_PIN, 32'h1, r);
        wait_update();
        check("osc", 64'(osc), 64'h98);
        check("fb off", 64'(fb_en), 64'h0);
        repeat (4) tick();
        check("phase", 64'(phase), 64'(`DNCR_CF_QUARTER));
        check("sf path", 64'(sf_path), 64'h0);
        $display("test pin update done");
        // center gate off then on, transfer by a write to the last address
        port_wr(`DNCR_ADDR_SIC, 8'h00);
        port_wr(`DNCR_ADDR_UPD, 8'h5a);
        wait_update();
        check("sic", 64'(sic), 64'h00);
        repeat (4) tick();
        check("phase off", 64'(phase), 64'h0);
        port_wr(`DNCR_ADDR_SIC, 8'h01);
        port_wr(`DNCR_ADDR_UPD, 8'h00);
        wait_update();
        repeat (4) tick();
        check("phase on", 64'(phase), 64'(`DNCR_CF_QUARTER));
        $display("test center gate done");
        // three masters land together on one transfer
        port_wr(`DNCR_ADDR_OSC, 8'he0);
        port_wr(`DNCR_ADDR_TTC, 8'h20);
        port_wr(`DNCR_ADDR_SIC, 8'h03);
        ahb_xfer(1'b1, `DNCR_HOFS_PIN, 32'h1, r);
        wait_update();
        check("osc", 64'(osc), 64'hf8);
        check("ttc", 64'(ttc), 64'h30);
        check("sic", 64'(sic), 64'h03);
        check("tim", 64'(tim), 64'h3);
        repeat (2) tick();
        check("sf path", 64'(sf_path), 64'({SF_WORD, 8'h00}));
        port_wr(`DNCR_ADDR_TTC, 8'h10);
        port_wr(`DNCR_ADDR_UPD, 8'hc3);
        wait_update();
        check("ttc", 64'(ttc), 64'h00);
        check("tim", 64'(tim), 64'h0);
        ahb_xfer(1'b0, 32'h0000_0010, 32'h0, r);
        check("unmapped", 64'(r), 64'h0);
        $display("test joint update done");
        // second reset in mid-run restores defaults and reruns the sequence
        @(posedge i_core_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        wait_init(8'hb8, 8'h00);
        $display("test second reset done");
        // serial path used and 30h timing: the sequence reruns with them
        ahb_xfer(1'b1, `DNCR_HOFS_CFG, 32'h3, r);
        ahb_xfer(1'b0, `DNCR_HOFS_CFG, 32'h0, r);
        check("cfg", 64'(r), 64'h3);
        wait_init(8'hf8, 8'h30);
        check("tim", 64'(tim), 64'h3);
        $display("test reset choices done");
        wrap_up();
    end
endmodule : test_dncr_nco_control_regs
`default_nettype wire
